// *** logic/tfa_params.svh ***
`ifndef TFA_PARAMS_SVH
`define TFA_PARAMS_SVH

// Synchroniser depth for every asynchronous input.
`define TFA_SYNC_STAGES 2
// Number of comparator fault inputs.
`define TFA_NUM_FAULTS  4
// Fault input positions in the synchronised fault vector.
`define TFA_F_OVERV     0
`define TFA_F_UNDERV    1
`define TFA_F_WEAK      2
`define TFA_F_MISTUNE   3
// Reset value of every latch and output.
`define TFA_OFF         1'b0
// Active value of a pulse or a set latch.
`define TFA_ON          1'b1

`endif

// *** logic/tfa_pkg.sv ***
package tfa_pkg;

  // Pushbutton press tracker states.
  typedef enum logic [1:0] {
    TFA_BTN_IDLE = 2'b00,
    TFA_BTN_HELD = 2'b01
  } tfa_btn_e;

endpackage

// *** logic/tfa_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tfa_params.svh"

module tfa_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Asynchronous level and its synchronised copy
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta_r   <= `TFA_OFF;
      sync_out <= `TFA_OFF;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

// *** logic/tfa_press.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tfa_params.svh"

module tfa_press (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Synchronised button level and one-cycle press pulse
  input  wire logic level_in,
  output logic      press_pulse
);

  tfa_pkg::tfa_btn_e state_r;

  // A held button produces exactly one pulse until it is released.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_r     <= tfa_pkg::TFA_BTN_IDLE;
      press_pulse <= `TFA_OFF;
    end else begin
      press_pulse <= `TFA_OFF;
      case (state_r)
        tfa_pkg::TFA_BTN_IDLE: begin
          if (level_in) begin
            state_r     <= tfa_pkg::TFA_BTN_HELD;
            press_pulse <= `TFA_ON;
          end
        end
        tfa_pkg::TFA_BTN_HELD: begin
          if (!level_in) begin
            state_r <= tfa_pkg::TFA_BTN_IDLE;
          end
        end
        default: begin
          state_r <= tfa_pkg::TFA_BTN_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// *** logic/tfa_alarm_latch.sv ***
// Functional notes
// - An active overvoltage fault forces rf shutback for as long as it lasts.
// - The overvoltage lamp lights on detection and stays lit until a general reset.
// - The remote overvoltage output sinks only while the overvoltage fault is present.
// - Supply and weak-drive faults release shutback as soon as their inputs clear.
// - A general reset press clears latched supply lamps whose faults are gone, and the weak lamp once its fault and any mistune trip are gone.
// - An active undervoltage fault forces shutback and lights the undervoltage lamp.
// - The remote undervoltage output sinks only while the undervoltage fault is present.
// - The undervoltage lamp stays lit after the fault until a general reset.
// - A weak rf drive indication forces shutback and lights the weak drive lamp.
// - The remote drive-level output sinks while a weak drive condition exists.
// - The weak drive lamp stays lit after the condition until a general reset.
// - A mistune trip forces shutback and lights the mistuned drive lamp.
// - A mistune trip also lights the weak drive lamp and sinks the drive-level output.
// - A mistune trip holds shutback, its lamp and both remote drive outputs until cleared.
// - A mistune clear press drops that latch, its lamp, shutback and remote drive outputs only.
// - The remote mistuned output sinks while the mistune latch is set.
`timescale 1ns/1ps
`default_nettype none
`include "tfa_params.svh"

module tfa_alarm_latch (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Comparator fault inputs, asynchronous, active high
  input  wire logic overvoltage_fault,
  input  wire logic undervoltage_fault,
  input  wire logic weak_drive_fault,
  input  wire logic mistune_fault,
  // Pushbuttons, asynchronous, active high while pressed
  input  wire logic alarm_reset_btn,
  input  wire logic mistune_latch_clear,
  // Rf control
  output logic      rf_shutback,
  // Panel lamps, high means lit
  output logic      overvoltage_lamp,
  output logic      undervoltage_lamp,
  output logic      weak_drive_lamp,
  output logic      mistuned_drive_lamp,
  // Remote status, high means sinking to ground
  output logic      remote_overvoltage_out,
  output logic      remote_undervoltage_out,
  output logic      remote_drive_level_out,
  output logic      remote_mistuned_out
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------

  logic [`TFA_NUM_FAULTS-1:0] fault_s;
  logic                       gen_lvl;
  logic                       tune_lvl;
  logic                       gen_press;
  logic                       tune_press;

  // The detectors are free-running comparators, so their levels move at any
  // instant; each one passes its own two-stage chain before any logic reads it.
  tfa_sync u_ov_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in (overvoltage_fault),
    .sync_out (fault_s[`TFA_F_OVERV])
  );

  tfa_sync u_uv_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in (undervoltage_fault),
    .sync_out (fault_s[`TFA_F_UNDERV])
  );

  tfa_sync u_wk_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in (weak_drive_fault),
    .sync_out (fault_s[`TFA_F_WEAK])
  );

  tfa_sync u_mt_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in (mistune_fault),
    .sync_out (fault_s[`TFA_F_MISTUNE])
  );

  tfa_sync u_gsync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in (alarm_reset_btn),
    .sync_out (gen_lvl)
  );

  tfa_sync u_tsync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in (mistune_latch_clear),
    .sync_out (tune_lvl)
  );

  tfa_press u_gpress (
    .clock       (clock),
    .nrst        (nrst),
    .level_in    (gen_lvl),
    .press_pulse (gen_press)
  );

  tfa_press u_tpress (
    .clock       (clock),
    .nrst        (nrst),
    .level_in    (tune_lvl),
    .press_pulse (tune_press)
  );

  // ----------------------------------------------------------------
  // Shared decoding
  // ----------------------------------------------------------------

  // A lamp or trip latch: a live set term holds it, and a press clears it
  // only once the set term is gone, so a fault present at the press survives.
  function automatic logic hold_next(
    input logic set_in,
    input logic held_in,
    input logic clear_in
  );
    return set_in | (held_in & ~clear_in);
  endfunction

  // Drive trouble is a weak drive level or a held mistune trip; shutback and
  // the drive-level status line must treat both alike.
  function automatic logic drive_trouble(
    input logic weak_in,
    input logic mistune_in
  );
    return weak_in | mistune_in;
  endfunction

  // ----------------------------------------------------------------
  // Alarm latch next values
  // ----------------------------------------------------------------

  logic ov_f;
  logic uv_f;
  logic wk_f;
  logic mt_f;
  logic ov_lamp_r;
  logic uv_lamp_r;
  logic wk_lamp_r;
  logic mt_lamp_r;
  logic mistune_r;
  logic shutback_r;
  logic ov_remote_r;
  logic uv_remote_r;
  logic drive_remote_r;
  logic mt_remote_r;
  logic wk_set;
  logic ov_nxt;
  logic uv_nxt;
  logic wk_nxt;
  logic mistune_nxt;
  logic drive_nxt;
  logic shutback_nxt;

  assign ov_f = fault_s[`TFA_F_OVERV];
  assign uv_f = fault_s[`TFA_F_UNDERV];
  assign wk_f = fault_s[`TFA_F_WEAK];
  assign mt_f = fault_s[`TFA_F_MISTUNE];

  // A held mistune trip keeps the weak lamp set, so the weak lamp can only go
  // out at a general reset that comes after the mistune clear.
  assign wk_set = wk_f | mt_f | mistune_r;

  // An active fault always wins over a reset press, so no event is lost.
  assign ov_nxt       = hold_next(ov_f, ov_lamp_r, gen_press);
  assign uv_nxt       = hold_next(uv_f, uv_lamp_r, gen_press);
  assign wk_nxt       = hold_next(wk_set, wk_lamp_r, gen_press);
  assign mistune_nxt  = hold_next(mt_f, mistune_r, tune_press);
  assign drive_nxt    = drive_trouble(wk_f, mistune_nxt);
  assign shutback_nxt = ov_f | uv_f | drive_nxt;

  // ----------------------------------------------------------------
  // Trip and lamp latches
  // ----------------------------------------------------------------

  // The mistune latch ignores the general reset; only its own button clears it.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mistune_r <= `TFA_OFF;
    end else begin
      mistune_r <= mistune_nxt;
    end
  end

  // Lamps are cleared only by a press, never by a fault going away.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ov_lamp_r <= `TFA_OFF;
    end else begin
      ov_lamp_r <= ov_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      uv_lamp_r <= `TFA_OFF;
    end else begin
      uv_lamp_r <= uv_nxt;
    end
  end

  // The weak lamp also records mistune trips, since a detuned drive is a
  // drive fault as far as the operator is concerned.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wk_lamp_r <= `TFA_OFF;
    end else begin
      wk_lamp_r <= wk_nxt;
    end
  end

  // The mistune lamp has a flip-flop of its own beside the trip latch, so the
  // lamp driver and the trip logic load separate nets.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mt_lamp_r <= `TFA_OFF;
    end else begin
      mt_lamp_r <= mistune_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Shutback and remote status
  // ----------------------------------------------------------------

  // Shutback follows live faults and the held trip only, so latched lamps
  // never hold power down.
  // A detector edge reaches shutback three clock edges later; the two sync
  // stages and the output flip-flop cost that much, but against the analog fault time scales this is
  // still an immediate trip.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      shutback_r <= `TFA_OFF;
    end else begin
      shutback_r <= shutback_nxt;
    end
  end

  // The remote lines report live conditions and never latch, except through
  // the held mistune trip.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ov_remote_r <= `TFA_OFF;
    end else begin
      ov_remote_r <= ov_f;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      uv_remote_r <= `TFA_OFF;
    end else begin
      uv_remote_r <= uv_f;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      drive_remote_r <= `TFA_OFF;
    end else begin
      drive_remote_r <= drive_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      mt_remote_r <= `TFA_OFF;
    end else begin
      mt_remote_r <= mistune_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Every output is a flip-flop of its own, so no pin glitches while the
  // latch terms around it settle.
  assign rf_shutback             = shutback_r;
  assign overvoltage_lamp        = ov_lamp_r;
  assign undervoltage_lamp       = uv_lamp_r;
  assign weak_drive_lamp         = wk_lamp_r;
  assign mistuned_drive_lamp     = mt_lamp_r;
  assign remote_overvoltage_out  = ov_remote_r;
  assign remote_undervoltage_out = uv_remote_r;
  assign remote_drive_level_out  = drive_remote_r;
  assign remote_mistuned_out     = mt_remote_r;

endmodule

`default_nettype wire

// *** tb/tfa_alarm_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module tfa_alarm_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Detector levels and buttons
  input wire logic overvoltage_fault,
  input wire logic undervoltage_fault,
  input wire logic weak_drive_fault,
  input wire logic mistune_fault,
  input wire logic alarm_reset_btn,
  input wire logic mistune_latch_clear,
  // Outputs of the latch
  input wire logic rf_shutback,
  input wire logic overvoltage_lamp,
  input wire logic undervoltage_lamp,
  input wire logic weak_drive_lamp,
  input wire logic mistuned_drive_lamp,
  input wire logic remote_overvoltage_out,
  input wire logic remote_undervoltage_out,
  input wire logic remote_drive_level_out,
  input wire logic remote_mistuned_out
);
  // ----
  // Settling
  // ----
  // The sync chains show reset values for three edges, so checks wait them out.
  logic [1:0] up_r;
  always_ff @(posedge clock) begin
    if (!nrst) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  wire up = (up_r == 2'h3);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_ov; up |-> remote_overvoltage_out == $past(overvoltage_fault, 3); endproperty
  property p_uv; up |-> remote_undervoltage_out == $past(undervoltage_fault, 3); endproperty
  property p_sb; up |-> rf_shutback == ($past(overvoltage_fault, 3) |
    $past(undervoltage_fault, 3) | $past(weak_drive_fault, 3) | remote_mistuned_out); endproperty
  property p_dl; up |-> remote_drive_level_out == ($past(weak_drive_fault, 3) |
    remote_mistuned_out); endproperty
  property p_mt; mistuned_drive_lamp == remote_mistuned_out; endproperty
  property p_lit; up |-> (overvoltage_lamp | !remote_overvoltage_out) &
    (undervoltage_lamp | !remote_undervoltage_out) & (weak_drive_lamp | !remote_drive_level_out);
  endproperty
  property p_ovc; up && $fell(overvoltage_lamp) |->
    $past(alarm_reset_btn, 4) && !remote_overvoltage_out; endproperty
  property p_wkc; up && $fell(weak_drive_lamp) |->
    $past(alarm_reset_btn, 4) && !remote_drive_level_out; endproperty
  a_ov: assert property (p_ov) else $error("remote ov wrong");
  a_uv: assert property (p_uv) else $error("remote uv wrong");
  a_sb: assert property (p_sb) else $error("shutback wrong");
  a_dl: assert property (p_dl) else $error("drive level wrong");
  a_mt: assert property (p_mt) else $error("mistune pair wrong");
  a_lit: assert property (p_lit) else $error("lamp dark");
  a_ovc: assert property (p_ovc) else $error("ov lamp cleared");
  a_wkc: assert property (p_wkc) else $error("weak lamp cleared");
  c_mis: cover property ($rose(mistuned_drive_lamp));
  c_clr: cover property ($fell(overvoltage_lamp));
  c_wk: cover property (weak_drive_lamp && !remote_drive_level_out);
endmodule
`default_nettype wire

// *** tb/tfa_field_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tfa_field_model (
  // Levels asked for by the bench
  input wire logic [5:0] want,
  // Detector outputs and panel buttons
  output logic     [5:0] pins
);
  // Ideal comparators: threshold crossings are decided by the bench.
  assign pins = want;
endmodule
`default_nettype wire

// *** tb/tfa_alarm_latch_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tfa_alarm_latch_tb_top;
  logic clock, nrst, overvoltage_fault, undervoltage_fault, weak_drive_fault, mistune_fault;
  logic alarm_reset_btn, mistune_latch_clear, rf_shutback, overvoltage_lamp;
  logic undervoltage_lamp, weak_drive_lamp, mistuned_drive_lamp, remote_overvoltage_out;
  logic remote_undervoltage_out, remote_drive_level_out, remote_mistuned_out;
  logic [5:0] want;
  logic [31:0] seed;
  logic [8:0] e;
  logic [3:0] lit;
  int mismatches, total_checks;
  tfa_alarm_latch uut (.*);
  wire [5:0] pins;
  tfa_field_model field (.want(want), .pins(pins));
  assign {mistune_latch_clear, alarm_reset_btn, mistune_fault, weak_drive_fault,
    undervoltage_fault, overvoltage_fault} = pins;
  wire [8:0] obs = {rf_shutback, mistuned_drive_lamp, weak_drive_lamp, undervoltage_lamp,
    overvoltage_lamp, remote_mistuned_out, remote_drive_level_out, remote_undervoltage_out,
    remote_overvoltage_out};
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [8:0] model(input logic [3:0] f, input logic [3:0] l);
    return {(|f[2:0]) | l[3], l, l[3], f[2] | l[3], f[1:0]};
  endfunction
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Held for three cycles, then a long release so the next press is a new one.
  task automatic press(input int b);
    want[b] = 1'b1;
    idle(3);
    want[b] = 1'b0;
    idle(6);
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t saw %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #100000;
    mismatches++;
    end_of_test;
  end
  initial begin
    want = 6'h00; nrst = 1'b0; seed = 32'h2BCB; lit = 4'h0; mismatches = 0; total_checks = 0;
    idle(10);
    nrst = 1'b1;
    idle(2);
    for (int i = 0; i < 4; i++) begin
      e = model(4'(1 << i), (i == 3) ? 4'hC : 4'(1 << i));
      want[i] = 1'b1;
      idle(4);
      chk(obs, e);
      want[i] = 1'b0;
      idle(4);
      e = model(4'h0, e[7:4]);
      chk(obs, e);
      press(4);
      chk(obs, (i == 3) ? e : 9'h000);
      press(5);
      chk(obs, (i == 3) ? 9'h040 : 9'h000);
      press(4);
      chk(obs, 9'h000);
    end
    want[0] = 1'b1;
    idle(4);
    want[4] = 1'b1;
    idle(6);
    chk(obs, 9'h111);
    want[0] = 1'b0;
    idle(8);
    chk(obs, 9'h010);
    want[4] = 1'b0;
    idle(4);
    press(4);
    chk(obs, 9'h000);
    repeat (40) begin
      seed = lfsr(seed);
      want[3:0] = seed[3:0];
      lit = lit | {seed[3], seed[3:2] != 2'h0, seed[1:0]};
      idle(4 + int'(seed[6:4]));
      chk(obs, model(seed[3:0], lit));
    end
    want = 6'h00;
    idle(4);
    press(5);
    press(4);
    chk(obs, 9'h000);
    end_of_test;
  end
endmodule
bind tfa_alarm_latch tfa_alarm_checker chk (.*);
`default_nettype wire
